// ==== trace_trigger_event_logic.v ====
// trigger-event logic of a trace buffer unit with a wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "trig_consts.vh"

module trace_trigger_event_logic
(
    input  wire               clk,
    input  wire               reset,
    input  wire               ce,
    // wishbone classic slave
    input  wire               wb_cyc_i,
    input  wire               wb_stb_i,
    input  wire               wb_we_i,
    input  wire [7:0]         wb_adr_i,
    input  wire [3:0]         wb_sel_i,
    input  wire [31:0]        wb_dat_i,
    output reg  [31:0]        wb_dat_o,
    output reg                wb_ack_o,
    // trace unit side
    input  wire               trig_det,
    input  wire               trig_tied,
    input  wire [`OPID_W-1:0] trig_op_id,
    input  wire               byte_valid,
    input  wire [`OPID_W-1:0] byte_op_id,
    output reg                byte_ready,
    output reg                flush_req,
    input  wire               flush_done,
    // event outputs
    output reg                trigger_event_pulse,
    output reg                mgmt_event_pulse,
    output reg                irq_flag,
    output reg                stopped_flag,
    output reg                attr_valid,
    output reg  [`OPID_W-1:0] attr_op_id
);

    // buffer_limit_register contents, then the base and write pointer registers
    reg                  enable_r;        // unit enabled
    reg  [1:0]           mode_r;          // trigger_mode_field
    reg  [`ADDR_W-1:0]   limit_addr_r;    // first address past buffer
    reg  [`ADDR_W-1:0]   base_addr_r;     // base pointer
    reg  [`ADDR_W-1:0]   wptr_r;          // current write pointer

    // buffer_status_register contents (flags have their own flops)
    reg                  trigger_seen_flag;
    reg  [5:0]           event_class_field;
    reg  [5:0]           buffer_status_code;

    // flush bookkeeping
    reg                  flush_busy_r;    // a requested flush is open
    reg                  flush_stop_r;    // that flush was asked in stop mode

    // bus decode
    wire                 bus_req;
    wire                 bus_wr;
    wire [31:0]          wmask;
    wire [31:0]          limit_word;
    wire [31:0]          status_word;
    wire [31:0]          attr_word;
    wire [31:0]          limit_nxt;
    wire [31:0]          base_nxt;
    wire [31:0]          wptr_nxt;
    wire [31:0]          count_nxt;
    wire [31:0]          status_nxt;

    // trace byte and counter
    wire                 byte_fire;
    wire [`CNT_W-1:0]    count;
    wire                 count_zero;
    wire                 count_one;
    wire                 count_load;
    wire                 count_dec;

    // event causes
    wire                 det_zero_cause;
    wire                 countdown_cause;
    wire                 event_fire;
    wire                 flush_wanted;
    wire                 flush_finish;

    // a request is live while cycle and strobe are both high
    assign bus_req = wb_cyc_i && wb_stb_i;

    // writes land on the edge where the master sees ack, not before
    assign bus_wr  = bus_req && wb_we_i && wb_ack_o;

    // byte lanes expanded to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : lane
            assign wmask[g*8+7:g*8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    // register images as software sees them
    assign limit_word = {limit_addr_r, 13'h0000, mode_r, enable_r};
    assign status_word = {event_class_field, 3'h0, irq_flag,
                          trigger_seen_flag, 3'h0, stopped_flag,
                          11'h000, buffer_status_code};
    assign attr_word  = {23'h000000, attr_valid, attr_op_id};

    // merged write values, untouched lanes keep their contents
    assign limit_nxt  = (limit_word & ~wmask) | (wb_dat_i & wmask);
    assign base_nxt   = ({16'h0000, base_addr_r} & ~wmask)
                        | (wb_dat_i & wmask);
    assign wptr_nxt   = ({16'h0000, wptr_r} & ~wmask)
                        | (wb_dat_i & wmask);
    assign count_nxt  = (count & ~wmask) | (wb_dat_i & wmask);
    assign status_nxt = (status_word & ~wmask) | (wb_dat_i & wmask);

    // trace bytes are taken only while the ready flop is high
    assign byte_fire  = byte_valid && byte_ready;

    // software writes to the counter set the post-trigger length
    assign count_load = bus_wr && (wb_adr_i == `OFS_COUNT);

    // count down one per written byte once the trigger was seen
    assign count_dec  = byte_fire && trigger_seen_flag
                        && !count_zero;

    // trigger counter
    trig_counter u_counter
    (
        .clk      (clk),
        .reset    (reset),
        .ce       (ce),
        .load     (count_load),
        .load_val (count_nxt),
        .dec      (count_dec),
        .count_r  (count),
        .zero     (count_zero),
        .at_one   (count_one)
    );

    // trigger arriving with nothing left to count
    assign det_zero_cause  = trig_det && count_zero
                             && !trigger_seen_flag;

    // the byte that brings the counter from one to zero
    assign countdown_cause = count_dec && count_one;

    // one event at a time, and only while enabled
    assign event_fire = enable_r && !flush_busy_r
                        && (det_zero_cause || countdown_cause);

    // ignore mode and an already stopped unit never flush
    assign flush_wanted = event_fire && !stopped_flag
                          && (mode_r == `MODE_STOP
                              || mode_r == `MODE_IRQ);

    // the trace unit answers our open request; stray answers are dropped
    assign flush_finish = flush_busy_r && flush_done;

    // bus answer: ack one cycle after the request, dropped after one cycle
    always @(posedge clk)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `RST_WORD;
        end
        else if (ce)
        begin
            wb_ack_o <= bus_req && !wb_ack_o;
            // read data is latched with the ack; unmapped reads give zero
            case (wb_adr_i)
                `OFS_LIMIT:  wb_dat_o <= limit_word;
                `OFS_BASE:   wb_dat_o <= {16'h0000, base_addr_r};
                `OFS_WPTR:   wb_dat_o <= {16'h0000, wptr_r};
                `OFS_COUNT:  wb_dat_o <= count;
                `OFS_STATUS: wb_dat_o <= status_word;
                `OFS_ATTR:   wb_dat_o <= attr_word;
                default:     wb_dat_o <= `RST_WORD;
            endcase
        end
    end

    // limit and base registers, written by software only
    always @(posedge clk)
    begin
        if (reset)
        begin
            enable_r     <= 1'b0;
            mode_r       <= `MODE_STOP;
            limit_addr_r <= `RST_ADDR;
            base_addr_r  <= `RST_ADDR;
        end
        else if (ce && bus_wr)
        begin
            if (wb_adr_i == `OFS_LIMIT)
            begin
                enable_r     <= limit_nxt[`LIM_EN_BIT];
                mode_r       <= limit_nxt[`LIM_MODE_HI:`LIM_MODE_LO];
                limit_addr_r <= limit_nxt[`LIM_ADDR_HI:`LIM_ADDR_LO];
            end
            if (wb_adr_i == `OFS_BASE)
                base_addr_r  <= base_nxt[`ADDR_W-1:0];
        end
    end

    // write pointer: advances per accepted byte, wraps to base at limit;
    // once collection stops no byte is accepted, so it rests on the
    // byte after the last one written, or on base after a wrap
    always @(posedge clk)
    begin
        if (reset)
            wptr_r <= `RST_ADDR;
        else if (ce)
        begin
            if (byte_fire)
            begin
                if (wptr_r + 16'h0001 == limit_addr_r)
                    wptr_r <= base_addr_r;
                else
                    wptr_r <= wptr_r + 16'h0001;
            end
            else if (bus_wr && wb_adr_i == `OFS_WPTR)
                wptr_r <= wptr_nxt[`ADDR_W-1:0];
        end
    end

    // byte acceptance keeps running after the event until one cycle after the stop
    // flag lands; registered so the ready output is a clean flop
    always @(posedge clk)
    begin
        if (reset)
            byte_ready <= 1'b0;
        else if (ce)
            byte_ready <= enable_r && !stopped_flag;
    end

    // flush request: raised on the event, held until completion
    always @(posedge clk)
    begin
        if (reset)
        begin
            flush_busy_r <= 1'b0;
            flush_stop_r <= 1'b0;
            flush_req    <= 1'b0;
        end
        else if (ce)
        begin
            if (flush_wanted)
            begin
                flush_busy_r <= 1'b1;
                flush_req    <= 1'b1;
                flush_stop_r <= (mode_r == `MODE_STOP);
            end
            else if (flush_finish)
            begin
                flush_busy_r <= 1'b0;
                flush_req    <= 1'b0;
            end
        end
    end

    // single-cycle pulses toward the monitor and the management logic
    always @(posedge clk)
    begin
        if (reset)
        begin
            trigger_event_pulse <= 1'b0;
            mgmt_event_pulse    <= 1'b0;
        end
        else if (ce)
        begin
            // event_fire cannot repeat back to back, since a flush or the
            // seen flag blocks the next one, but the pulse is still one wide
            trigger_event_pulse <= event_fire;
            mgmt_event_pulse    <= flush_finish;
        end
    end

    // attribution of each event to the trace operation that caused it
    always @(posedge clk)
    begin
        if (reset)
        begin
            attr_valid <= 1'b0;
            attr_op_id <= `RST_OPID;
        end
        else if (ce && event_fire)
        begin
            if (countdown_cause)
            begin
                attr_valid <= 1'b1;
                attr_op_id <= byte_op_id;
            end
            else if (trig_tied)
            begin
                attr_valid <= 1'b1;
                attr_op_id <= trig_op_id;
            end
            else
            begin
                attr_valid <= 1'b0;
                attr_op_id <= `RST_OPID;
            end
        end
    end

    // status register: software write first, then hardware sets on top,
    // so an event in the clearing cycle is never lost
    always @(posedge clk)
    begin
        if (reset)
        begin
            trigger_seen_flag  <= 1'b0;
            irq_flag           <= 1'b0;
            stopped_flag       <= 1'b0;
            event_class_field  <= `CLASS_OTHER;
            buffer_status_code <= `RST_CODE;
        end
        else if (ce)
        begin
            if (bus_wr && wb_adr_i == `OFS_STATUS)
            begin
                trigger_seen_flag  <= status_nxt[`ST_TRIG_BIT];
                irq_flag           <= status_nxt[`ST_IRQ_BIT];
                stopped_flag       <= status_nxt[`ST_STOP_BIT];
                event_class_field  <= status_nxt[`ST_CLASS_HI:`ST_CLASS_LO];
                buffer_status_code <= status_nxt[`ST_CODE_HI:`ST_CODE_LO];
            end
            // any detected trigger while enabled marks the seen flag
            if (enable_r && trig_det)
                trigger_seen_flag <= 1'b1;
            // every completed flush raises the interrupt flag
            if (flush_finish)
                irq_flag <= 1'b1;
            // stop mode alone stops, and only if nothing stopped it first
            if (flush_finish && flush_stop_r && !stopped_flag)
            begin
                stopped_flag       <= 1'b1;
                event_class_field  <= `CLASS_OTHER;
                buffer_status_code <= `CODE_TRIGGER;
            end
        end
    end

endmodule // trace_trigger_event_logic

`default_nettype wire

// ==== trace_trigger_event_logic_chk.sv ====
// port checker for the trigger-event logic
`timescale 1ns/100ps
`default_nettype none
`include "trig_consts.vh"
module trace_trigger_event_logic_chk
(
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               ce,
    input wire logic               wb_we_i,
    input wire logic               wb_ack_o,
    input wire logic               byte_ready,
    input wire logic               flush_req,
    input wire logic               flush_done,
    input wire logic               trigger_event_pulse,
    input wire logic               mgmt_event_pulse,
    input wire logic               irq_flag,
    input wire logic               stopped_flag,
    input wire logic               attr_valid,
    input wire logic [`OPID_W-1:0] attr_op_id
);
    // a frozen clock enable stalls every flop, so checks pause too
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !ce);
    // flush completion taken by the design
    sequence s_done;
        flush_req && flush_done;
    endsequence
    // pulse gone again one cycle later
    sequence s_drop;
        ##1 !trigger_event_pulse;
    endsequence
    a_pulse_single: assert property (
        trigger_event_pulse |-> s_drop)
        else $error("trigger pulse longer than one cycle");
    a_flush_cause: assert property (
        $rose(flush_req) |-> trigger_event_pulse)
        else $error("flush request without trigger pulse");
    a_flush_hold: assert property (
        flush_req && !flush_done |=> flush_req)
        else $error("flush request dropped before done");
    a_done_mgmt: assert property (
        s_done |=> mgmt_event_pulse && irq_flag && !flush_req)
        else $error("flush done without management event");
    a_mgmt_cause: assert property (
        mgmt_event_pulse |-> $past(flush_req && flush_done))
        else $error("management event without flush done");
    a_busy_refuse: assert property (
        $past(flush_req) |-> !trigger_event_pulse)
        else $error("trigger event while flush outstanding");
    a_stop_ready: assert property (
        $rose(stopped_flag) |=> !byte_ready)
        else $error("bytes still taken after stop");
    a_attr_moves: assert property (
        $changed(attr_op_id) || $changed(attr_valid)
        |-> trigger_event_pulse)
        else $error("attribution changed without event");
    a_attr_zero: assert property (
        !attr_valid |-> attr_op_id == 8'h00)
        else $error("operation id without attribution");
    a_irq_by_sw: assert property (
        $fell(irq_flag) |-> $past(wb_ack_o && wb_we_i))
        else $error("interrupt flag cleared by hardware");
    a_stop_by_sw: assert property (
        $fell(stopped_flag) |-> $past(wb_ack_o && wb_we_i))
        else $error("stopped flag cleared by hardware");
endmodule // trace_trigger_event_logic_chk

bind trace_trigger_event_logic trace_trigger_event_logic_chk i_chk
(
    .clk(clk), .reset(reset), .ce(ce), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .byte_ready(byte_ready),
    .flush_req(flush_req), .flush_done(flush_done),
    .trigger_event_pulse(trigger_event_pulse),
    .mgmt_event_pulse(mgmt_event_pulse), .irq_flag(irq_flag),
    .stopped_flag(stopped_flag), .attr_valid(attr_valid),
    .attr_op_id(attr_op_id)
);
`default_nettype wire

// ==== trace_trigger_event_logic_tb.sv ====
// self-checking bench for the trigger-event logic
`timescale 1ns/100ps
`default_nettype none
`include "trig_consts.vh"
module trace_trigger_event_logic_tb;
    logic        clk = 1'b0, reset = 1'b1, ce = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;   // register offset
    logic [3:0]  wb_sel_i = 4'hf;    // all lanes
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, byte_ready, flush_req, flush_done;
    logic        trig_det, trig_tied, byte_valid, attr_valid;
    logic [7:0]  trig_op_id, byte_op_id, attr_op_id;
    logic        trigger_event_pulse, mgmt_event_pulse;
    logic        irq_flag, stopped_flag;
    logic [3:0]  flush_lat = 4'h0;   // partner answer delay
    integer      seed = 32'h8986;    // fixed random seed
    int          err_total, n_compared, cyc_n, n, k;
    int          ev_cnt, mg_cnt, ev_exp, mg_exp;
    // reference model of flags, counter and pointer
    logic        en_m = 0, seen_m = 0, stop_m = 0, irq_m = 0, av_m = 0;
    logic [1:0]  mode_m = 2'h0;
    logic [5:0]  code_m = 6'h00;
    logic [7:0]  op_m = 8'h00, op;
    logic [31:0] cnt_m = 32'h0, ptr_m = 32'h0, q;

    always #25 clk = ~clk;

    trace_trigger_event_logic i_dut
    (
        .clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .trig_det(trig_det),
        .trig_tied(trig_tied), .trig_op_id(trig_op_id),
        .byte_valid(byte_valid), .byte_op_id(byte_op_id),
        .byte_ready(byte_ready), .flush_req(flush_req),
        .flush_done(flush_done),
        .trigger_event_pulse(trigger_event_pulse),
        .mgmt_event_pulse(mgmt_event_pulse), .irq_flag(irq_flag),
        .stopped_flag(stopped_flag), .attr_valid(attr_valid),
        .attr_op_id(attr_op_id)
    );

    trace_unit_model i_tu
    (
        .clk(clk), .byte_ready(byte_ready), .flush_req(flush_req),
        .flush_lat(flush_lat), .trig_det(trig_det),
        .trig_tied(trig_tied), .trig_op_id(trig_op_id),
        .byte_valid(byte_valid), .byte_op_id(byte_op_id),
        .flush_done(flush_done)
    );

    // count pulses and cut a hung run short
    always @(posedge clk)
    begin
        ev_cnt += (trigger_event_pulse === 1'b1);
        mg_cnt += (mgmt_event_pulse === 1'b1);
        cyc_n++;
        if (cyc_n == 20000)
        begin
            err_total++;
            finish_test;
        end
    end

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1)
            @(posedge clk);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // model of one trigger event; ignore modes and stop skip flush
    task automatic hit(input logic t, input logic [7:0] o);
        ev_exp++;
        av_m = t;
        op_m = t ? o : 8'h00;
        if (!mode_m[1] && !stop_m)
        begin
            mg_exp++;
            irq_m = 1'b1;
            stop_m = (mode_m == 2'h0);
            code_m = stop_m ? 6'h02 : code_m;
        end
    endtask

    task automatic set_limit(input logic en, input logic [1:0] m);
        wb(1'b1, `OFS_LIMIT, {16'h0005, 13'h0, m, en}, q);
        en_m = en;
        mode_m = m;
    endtask

    task automatic set_status(input logic [31:0] v);
        wb(1'b1, `OFS_STATUS, v, q);
        {irq_m, seen_m, stop_m, code_m} = {v[22:21], v[17], v[5:0]};
    endtask

    task automatic trig(input logic t, input logic [7:0] o);
        i_tu.send_trig(t, o);
        if (en_m && cnt_m == 0 && !seen_m)
            hit(t, o);
        seen_m = seen_m | en_m;
    endtask

    task automatic bytes(input int c, input logic [7:0] o);
        i_tu.send_bytes(c, o);
        repeat (c)
        begin
            // small buffer of five bytes, so the wrap to base is reached
            ptr_m = (ptr_m + 1 == 5) ? 0 : ptr_m + 1;
            if (seen_m && cnt_m != 0)
            begin
                cnt_m--;
                if (cnt_m == 0)
                    hit(1'b1, o);
            end
        end
    endtask

    // let any flush finish, then compare outputs and registers
    task automatic check_all;
        n = 0;
        repeat (4) @(posedge clk);
        while (flush_req !== 1'b0 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        cmp("events", ev_exp, ev_cnt);
        cmp("mgmt", mg_exp, mg_cnt);
        cmp("irq", irq_m, irq_flag);
        cmp("stopped", stop_m, stopped_flag);
        cmp("attr", {av_m, op_m}, {attr_valid, attr_op_id});
        wb(1'b0, `OFS_STATUS, 32'h0, q);
        cmp("stat", {irq_m, seen_m, 3'h0, stop_m, 17'(code_m)}, q);
        wb(1'b0, `OFS_COUNT, 32'h0, q);
        cmp("count", cnt_m, q);
        wb(1'b0, `OFS_WPTR, 32'h0, q);
        cmp("pointer", ptr_m, q);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, 8'h20, 32'h0, q);
        cmp("unmapped", 32'h0, q);
        check_all;
        // direct trigger in every mode, a repeat must be refused
        for (int m = 0; m < 4; m++)
        begin
            set_status(32'h0);
            set_limit(1'b1, m[1:0]);
            flush_lat <= 4'($random(seed));
            op = 8'($random(seed));
            trig(~m[0], op);
            check_all;
            trig(1'b1, op + 8'h01);
            check_all;
        end
        // counted delay in stop and interrupt-only modes
        for (int m = 0; m < 2; m++)
        begin
            set_status(32'h0);
            set_limit(1'b1, m[1:0]);
            k = 1 + ($random(seed) & 7);
            wb(1'b1, `OFS_COUNT, 32'(k), q);
            cnt_m = 32'(k);
            trig(1'b0, 8'h00);
            op = 8'($random(seed));
            bytes(k - 1, op + 8'h01);
            check_all;
            bytes(1, op);
            check_all;
        end
        // event while already stopped: pulse only
        set_status(32'h0002_0000);
        set_limit(1'b1, 2'h0);
        trig(1'b1, op);
        check_all;
        // disabled unit ignores triggers
        set_limit(1'b0, 2'h0);
        set_status(32'h0);
        trig(1'b1, op);
        check_all;
        // a second cause while a flush is open is refused, bytes still flow
        set_limit(1'b1, 2'h0);
        flush_lat <= 4'hf;
        trig(1'b1, op);
        wb(1'b1, `OFS_STATUS, 32'h0, q);
        i_tu.send_trig(1'b1, op + 8'h02);
        seen_m = 1'b1;
        bytes(2, op);
        check_all;
        finish_test;
    end
endmodule // trace_trigger_event_logic_tb
`default_nettype wire

// ==== trace_unit_model.sv ====
// far-side trace unit model: triggers, trace bytes, flush answers
`timescale 1ns/100ps
`default_nettype none
module trace_unit_model
(
    input  wire logic       clk,        // core clock
    input  wire logic       byte_ready, // design takes a byte
    input  wire logic       flush_req,  // design asks for a flush
    input  wire logic [3:0] flush_lat,  // extra cycles before done
    output var  logic       trig_det,   // detected trigger pulse
    output var  logic       trig_tied,  // trigger owned by an operation
    output var  logic [7:0] trig_op_id, // owning operation
    output var  logic       byte_valid, // trace byte offered
    output var  logic [7:0] byte_op_id, // operation of that byte
    output var  logic       flush_done  // flush finished pulse
);
    int wait_c; // cycles spent on the current flush
    // quiet lines at time zero
    initial
    begin
        trig_det = 1'b0;
        trig_tied = 1'b0;
        trig_op_id = 8'h00;
        byte_valid = 1'b0;
        byte_op_id = 8'h00;
        flush_done = 1'b0;
        wait_c = 0;
    end
    // one-cycle trigger, tied or untied to an operation
    task automatic send_trig(input logic t, input logic [7:0] o);
        @(posedge clk);
        trig_det <= 1'b1;
        trig_tied <= t;
        trig_op_id <= o;
        @(posedge clk);
        trig_det <= 1'b0;
        trig_tied <= 1'b0;
        trig_op_id <= ~o; // released id never shows the old value
    endtask
    // back-to-back bytes of one operation, held until taken
    task automatic send_bytes(input int k, input logic [7:0] o);
        if (k > 0)
        begin
            @(posedge clk);
            byte_valid <= 1'b1;
            byte_op_id <= o;
            repeat (k)
            begin
                @(posedge clk);
                while (byte_ready !== 1'b1)
                    @(posedge clk);
            end
            byte_valid <= 1'b0;
            byte_op_id <= ~o;
        end
    endtask
    // flush answer only once no byte is left waiting
    always @(posedge clk)
    begin
        flush_done <= 1'b0;
        if (flush_req && !flush_done && !byte_valid)
        begin
            if (wait_c >= flush_lat)
            begin
                flush_done <= 1'b1;
                wait_c <= 0;
            end
            else
                wait_c <= wait_c + 1;
        end
    end
endmodule // trace_unit_model
`default_nettype wire

// ==== trig_consts.vh ====
// constants for the trigger-event logic: offsets, fields, codes, widths
`ifndef TRIG_CONSTS_VH
`define TRIG_CONSTS_VH

// register byte offsets on the bus
`define OFS_LIMIT      8'h00
`define OFS_BASE       8'h04
`define OFS_WPTR       8'h08
`define OFS_COUNT      8'h0c
`define OFS_STATUS     8'h10
`define OFS_ATTR       8'h14

// widths
`define ADDR_W         16
`define OPID_W         8
`define CNT_W          32

// limit register fields
`define LIM_EN_BIT     0
`define LIM_MODE_LO    1
`define LIM_MODE_HI    2
`define LIM_ADDR_LO    16
`define LIM_ADDR_HI    31

// status register fields
`define ST_CODE_LO     0
`define ST_CODE_HI     5
`define ST_STOP_BIT    17
`define ST_TRIG_BIT    21
`define ST_IRQ_BIT     22
`define ST_CLASS_LO    26
`define ST_CLASS_HI    31

// attribution register fields
`define ATTR_VALID_BIT 8

// trigger modes
`define MODE_STOP      2'h0
`define MODE_IRQ       2'h1
`define MODE_IGNORE    2'h3

// values loaded on the stop-mode management event
`define CLASS_OTHER    6'h00
`define CODE_TRIGGER   6'h02

// reset values, and the counter decrement step
`define RST_WORD       32'h0000_0000
`define RST_ADDR       16'h0000
`define RST_OPID       8'h00
`define RST_CODE       6'h00
`define CNT_ONE        32'h0000_0001

`endif

// ==== trig_counter.v ====
// trigger counter: software load, decrement by one per byte, zero flag
`timescale 1ns/100ps
`default_nettype none
`include "trig_consts.vh"

module trig_counter
(
    input  wire              clk,
    input  wire              reset,
    input  wire              ce,
    input  wire              load,
    input  wire [`CNT_W-1:0] load_val,
    input  wire              dec,
    output reg  [`CNT_W-1:0] count_r,
    output wire              zero,
    output wire              at_one
);

    // a software load beats a decrement in the same cycle, so the
    // value that software wrote is never off by one
    always @(posedge clk)
    begin
        if (reset)
            count_r <= `RST_WORD;
        else if (ce)
        begin
            if (load)
                count_r <= load_val;
            else if (dec && !zero)
                count_r <= count_r - `CNT_ONE;
        end
    end

    assign zero   = (count_r == `RST_WORD);
    assign at_one = (count_r == `CNT_ONE);

endmodule // trig_counter

`default_nettype wire
